// ==== itas_map.svh ====
/*
  Constants for the I2C target port: address field layout, strap codes,
  byte framing and the data setup count used when a clock stretch ends.
  Assumes a 200 MHz core clock; included by the package, the address latch and the target.
*/
`ifndef ITAS_MAP_SVH
`define ITAS_MAP_SVH

// core clock rate and the data setup time kept before scl is let go
`define ITAS_CLK_MHZ          200
`define ITAS_DATA_SETUP_NS    250
`define ITAS_SETUP_CYC        ((`ITAS_DATA_SETUP_NS * `ITAS_CLK_MHZ + 999) / 1000)
`define ITAS_SETUP_W          6

// 7-bit address layout (address byte bits 7..1)
`define ITAS_ADDR_TOP         2'h1
`define ITAS_ADDR_FORCED      2'h3
`define ITAS_ADDR_W           7

// resistor strap codes
`define ITAS_CODE_PRIMARY     3'h0
`define ITAS_CODE_SECONDARY   3'h7

// byte framing
`define ITAS_BITS_PER_BYTE    4'h8
`define ITAS_IDX_SUBADDR      8'h00
`define ITAS_IDX_COUNT        8'h01
`define ITAS_IDX_MAX          8'hff

`endif

// ==== itas_pkg.sv ====
/*
  Types and the address assembly function of the I2C target port.
  Assumes itas_map.svh is on the include path.
*/
`include "itas_map.svh"

package itas_pkg;

  // byte-level protocol state of the target
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110,
    ST_IGNORE   = 3'b111
  } itas_state_t;

  // fixed top bits, strap pins (port 2 only) and the strap code
  function automatic logic [6:0] itas_build_addr(input logic       port2,
                                                 input logic       pin_a,
                                                 input logic       pin_b,
                                                 input logic [2:0] code);
    logic [1:0] mid;
    mid = port2 ? {pin_b, pin_a} : `ITAS_ADDR_FORCED;
    return {`ITAS_ADDR_TOP, mid, code};
  endfunction : itas_build_addr

endpackage : itas_pkg

// ==== itas_addr_latch.sv ====
/*
  Captures the strap pins and the decoded resistor code once at boot and
  forms the target address. Assumes decode_done rises once the strap
  decoder result is valid and stays meaningful only at that moment.
*/
`timescale 1ns/1ps
`include "itas_map.svh"

module itas_addr_latch (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // boot straps
  input  wire logic       port2_sel,
  input  wire logic       addr_strap_pin_a,
  input  wire logic       addr_strap_pin_b,
  input  wire logic [2:0] strap_code,
  input  wire logic       decode_done,
  // captured address
  output logic      [6:0] own_addr_q,
  output logic            locked_q,
  output logic            primary_q
);

  // pins and code are taken in the same cycle so they never mix boots
  always_ff @(posedge clk) begin
    if (!resetn) begin
      own_addr_q <= 7'h00;
      locked_q   <= 1'b0;
      primary_q  <= 1'b0;
    end else if (decode_done && !locked_q) begin
      own_addr_q <= itas_pkg::itas_build_addr(port2_sel, addr_strap_pin_a,
                                              addr_strap_pin_b, strap_code);
      primary_q  <= (strap_code == `ITAS_CODE_PRIMARY);
      locked_q   <= 1'b1;
    end
  end

  AST_ADDR_TOP: assert property (@(posedge clk) disable iff (!resetn)
    locked_q |-> own_addr_q[6:5] == `ITAS_ADDR_TOP)
    else $error("address top bits not 01");

  AST_PORT1_FORCE: assert property (@(posedge clk) disable iff (!resetn)
    (decode_done && !locked_q && !port2_sel) |=> own_addr_q[4:3] == `ITAS_ADDR_FORCED)
    else $error("port 1 address bits 4 and 5 not forced high");

  AST_SAME_SAMPLE: assert property (@(posedge clk) disable iff (!resetn)
    (decode_done && !locked_q) |=>
      own_addr_q == itas_pkg::itas_build_addr($past(port2_sel), $past(addr_strap_pin_a),
                                              $past(addr_strap_pin_b), $past(strap_code)))
    else $error("straps not captured together");

  AST_PRIMARY: assert property (@(posedge clk) disable iff (!resetn)
    locked_q |-> primary_q == (own_addr_q[2:0] == `ITAS_CODE_PRIMARY))
    else $error("primary flag does not follow strap code");

  AST_LOCK_STABLE: assert property (@(posedge clk) disable iff (!resetn)
    locked_q |=> locked_q && $stable(own_addr_q))
    else $error("address changed after boot");

endmodule : itas_addr_latch

// ==== itas_bus_cond.sv ====
/*
  Edge and bus condition detector for scl and sda. Assumes both inputs
  are already synchronous to clk; one register stage gives the history.
*/
`timescale 1ns/1ps

module itas_bus_cond (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // bus levels
  input  wire logic scl_i,
  input  wire logic sda_i,
  // detected events, one cycle each, and the registered sda level
  output logic      scl_rise_q,
  output logic      scl_fall_q,
  output logic      start_q,
  output logic      stop_q,
  output logic      sda_q
);

  logic scl_q;

  // previous levels, idle bus reads high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // start and stop are sda edges while scl stays high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_rise_q <= 1'b0;
      scl_fall_q <= 1'b0;
      start_q    <= 1'b0;
      stop_q     <= 1'b0;
    end else begin
      scl_rise_q <= scl_i && !scl_q;
      scl_fall_q <= !scl_i && scl_q;
      start_q    <= scl_i && scl_q && sda_q && !sda_i;
      stop_q     <= scl_i && scl_q && !sda_q && sda_i;
    end
  end

endmodule : itas_bus_cond

// ==== itas_target.sv ====
/*
  I2C target port: address match, byte receive with acknowledge, byte
  transmit, clock stretching while the core is busy, and the sub-address
  and byte count framing of host-interface commands.
  Assumes scl and sda inputs synchronous to clk, open-drain pads outside,
  and a boot sequence that pulses decode_done once the strap is decoded.
*/
// Summary of operation
// - after a byte the port holds scl low until the core can take or give more data.
// - a stretch may fall on any clock pulse and the controller copes with that.
// - the address is fixed at boot and nothing is answered until it is set and the port enabled.
// - address byte is 0,1, two strap pin bits, three strap code bits and read/write in bit 0.
// - port 1 forces address bits 4 and 5 high while port 2 takes them from the strap pins.
// - the strap pins are sampled in the same moment as the resistor strap code.
// - strap code 0 means grounded primary, 7 means open secondary, 1 to 6 the resistor steps.
// - the device with strap code zero owns the serial flash and masters the serial link.
// - the byte after the address byte is the sub-address choosing the command or register.
// - the strap pin address bits are assembled by core logic, not by dedicated pin hardware.
// - as a receiver the port acknowledges every byte by holding sda low across the ack pulse.
// - the port works at standard-mode and fast-mode rates.
`timescale 1ns/1ps
`include "itas_map.svh"

module itas_target (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // boot configuration
  input  wire logic       port2_sel,
  input  wire logic       addr_strap_pin_a,
  input  wire logic       addr_strap_pin_b,
  input  wire logic [2:0] strap_code,
  input  wire logic       decode_done,
  input  wire logic       port_enable,
  // i2c pads, open drain
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // address status
  output logic      [6:0] own_addr,
  output logic            addr_locked,
  output logic            primary,
  // received bytes toward the core
  output logic            wr_valid,
  output logic      [7:0] wr_data,
  output logic      [7:0] wr_index,
  input  wire logic       wr_ready,
  output logic      [7:0] sub_addr,
  output logic      [7:0] byte_count,
  // transmit bytes from the core
  output logic            rd_req,
  output logic      [7:0] rd_index,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  // transfer status
  output logic            busy
);

  itas_pkg::itas_state_t state_q;

  logic                   ev_rise;
  logic                   ev_fall;
  logic                   ev_start;
  logic                   ev_stop;
  logic                   sda_in;
  logic [3:0]             bit_cnt_q;
  logic [7:0]             shift_q;
  logic [7:0]             byte_idx_q;
  logic [`ITAS_SETUP_W-1:0] setup_cnt_q;
  logic                   rw_q;
  logic                   byte_done;
  logic                   resp_en;
  logic                   addr_match;
  logic                   wr_hs;
  logic                   rd_hs;
  logic                   rx_set;
  logic                   rd_set;

  localparam logic [`ITAS_SETUP_W-1:0] SETUP_CYC = `ITAS_SETUP_W'(`ITAS_SETUP_CYC);

  // boot-time address capture
  itas_addr_latch u_addr (
    .clk              (clk),
    .resetn           (resetn),
    .port2_sel        (port2_sel),
    .addr_strap_pin_a (addr_strap_pin_a),
    .addr_strap_pin_b (addr_strap_pin_b),
    .strap_code       (strap_code),
    .decode_done      (decode_done),
    .own_addr_q       (own_addr),
    .locked_q         (addr_locked),
    .primary_q        (primary)
  );

  // bus edges and conditions
  itas_bus_cond u_cond (
    .clk        (clk),
    .resetn     (resetn),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_rise_q (ev_rise),
    .scl_fall_q (ev_fall),
    .start_q    (ev_start),
    .stop_q     (ev_stop),
    .sda_q      (sda_in)
  );

  // decode of the current bus situation
  assign byte_done  = (bit_cnt_q == `ITAS_BITS_PER_BYTE);
  assign resp_en    = addr_locked && port_enable;
  assign addr_match = resp_en && (shift_q[7:1] == own_addr);
  assign wr_hs      = wr_valid && wr_ready;
  assign rd_hs      = rd_req && rd_valid;
  assign rx_set     = (state_q == itas_pkg::ST_RX) && ev_fall && byte_done;
  assign rd_set     = ev_fall && ((state_q == itas_pkg::ST_ADDR_ACK && rw_q) ||
                                  (state_q == itas_pkg::ST_TX_ACK));

  // protocol state; start and stop override everything, also mid-byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= itas_pkg::ST_IDLE;
    end else if (ev_stop) begin
      state_q <= itas_pkg::ST_IDLE;
    end else if (ev_start) begin
      state_q <= itas_pkg::ST_ADDR;
    end else begin
      unique case (state_q)
        itas_pkg::ST_IDLE:     state_q <= itas_pkg::ST_IDLE;
        itas_pkg::ST_ADDR: begin
          if (ev_fall && byte_done) begin
            state_q <= addr_match ? itas_pkg::ST_ADDR_ACK : itas_pkg::ST_IGNORE;
          end
        end
        itas_pkg::ST_ADDR_ACK: begin
          if (ev_fall) begin
            state_q <= rw_q ? itas_pkg::ST_TX : itas_pkg::ST_RX;
          end
        end
        itas_pkg::ST_RX: begin
          if (ev_fall && byte_done) begin
            state_q <= itas_pkg::ST_RX_ACK;
          end
        end
        itas_pkg::ST_RX_ACK: begin
          if (ev_fall) begin
            state_q <= itas_pkg::ST_RX;
          end
        end
        itas_pkg::ST_TX: begin
          if (ev_fall && byte_done) begin
            state_q <= itas_pkg::ST_TX_ACK;
          end
        end
        itas_pkg::ST_TX_ACK: begin
          // a nack ends our part; wait for the stop or a restart
          if (ev_rise && sda_in) begin
            state_q <= itas_pkg::ST_IGNORE;
          end else if (ev_fall) begin
            state_q <= itas_pkg::ST_TX;
          end
        end
        itas_pkg::ST_IGNORE:   state_q <= itas_pkg::ST_IGNORE;
      endcase
    end
  end

  // bit counter: counts rising edges of data bits, cleared past each ack
  always_ff @(posedge clk) begin
    if (!resetn || ev_start) begin
      bit_cnt_q <= 4'h0;
    end else if (ev_rise && (state_q == itas_pkg::ST_ADDR || state_q == itas_pkg::ST_RX ||
                             state_q == itas_pkg::ST_TX)) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end else if (ev_fall && (state_q == itas_pkg::ST_ADDR_ACK ||
                             state_q == itas_pkg::ST_RX_ACK ||
                             state_q == itas_pkg::ST_TX_ACK)) begin
      bit_cnt_q <= 4'h0;
    end
  end

  // shift register, msb first in both directions
  always_ff @(posedge clk) begin
    if (!resetn || ev_start) begin
      shift_q <= 8'h00;
    end else if (rd_hs) begin
      shift_q <= rd_data;
    end else if (ev_rise && (state_q == itas_pkg::ST_ADDR || state_q == itas_pkg::ST_RX)) begin
      shift_q <= {shift_q[6:0], sda_in};
    end else if (ev_rise && state_q == itas_pkg::ST_TX) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  // direction of the addressed transfer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rw_q <= 1'b0;
    end else if (state_q == itas_pkg::ST_ADDR && ev_fall && byte_done) begin
      rw_q <= shift_q[0];
    end
  end

  // byte position in the transfer; a restart begins the read at 0
  always_ff @(posedge clk) begin
    if (!resetn || ev_start) begin
      byte_idx_q <= 8'h00;
    end else if (ev_fall && byte_idx_q != `ITAS_IDX_MAX &&
                 (state_q == itas_pkg::ST_RX_ACK ||
                  (state_q == itas_pkg::ST_TX_ACK && !sda_in))) begin
      byte_idx_q <= byte_idx_q + 8'h01;
    end
  end

  // sda drive: ack low, transmit zeros low, released otherwise
  always_ff @(posedge clk) begin
    if (!resetn || ev_start || ev_stop) begin
      sda_oe <= 1'b0;
    end else if (rd_hs) begin
      sda_oe <= !rd_data[7];
    end else if (ev_fall) begin
      unique case (state_q)
        itas_pkg::ST_ADDR:     sda_oe <= byte_done && addr_match;
        itas_pkg::ST_RX:       sda_oe <= byte_done;
        itas_pkg::ST_TX:       sda_oe <= !byte_done && !shift_q[7];
        itas_pkg::ST_ADDR_ACK: sda_oe <= 1'b0;
        itas_pkg::ST_RX_ACK:   sda_oe <= 1'b0;
        itas_pkg::ST_TX_ACK:   sda_oe <= 1'b0;
        itas_pkg::ST_IDLE:     sda_oe <= 1'b0;
        itas_pkg::ST_IGNORE:   sda_oe <= 1'b0;
      endcase
    end
  end

  // received bytes wait here until the core takes them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_valid <= 1'b0;
      wr_data  <= 8'h00;
      wr_index <= 8'h00;
    end else if (rx_set) begin
      wr_valid <= 1'b1;
      wr_data  <= shift_q;
      wr_index <= byte_idx_q;
    end else if (wr_hs) begin
      wr_valid <= 1'b0;
    end
  end

  // command framing: first written byte selects, second gives the count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sub_addr   <= 8'h00;
      byte_count <= 8'h00;
    end else if (wr_hs && wr_index == `ITAS_IDX_SUBADDR) begin
      sub_addr   <= wr_data;
    end else if (wr_hs && wr_index == `ITAS_IDX_COUNT) begin
      byte_count <= wr_data;
    end
  end

  // transmit requests; the core answers index 0 with the byte count
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_req   <= 1'b0;
      rd_index <= 8'h00;
    end else if (rd_set && !(state_q == itas_pkg::ST_TX_ACK && sda_in)) begin
      rd_req   <= 1'b1;
      rd_index <= (state_q == itas_pkg::ST_TX_ACK) ? byte_idx_q + 8'h01 : byte_idx_q;
    end else if (rd_hs) begin
      rd_req   <= 1'b0;
    end
  end

  // after the core answers, sda settles before scl is released
  always_ff @(posedge clk) begin
    if (!resetn) begin
      setup_cnt_q <= '0;
    end else if (wr_hs || rd_hs) begin
      setup_cnt_q <= SETUP_CYC;
    end else if (setup_cnt_q != '0) begin
      setup_cnt_q <= setup_cnt_q - `ITAS_SETUP_W'(1);
    end
  end

  // clock stretch; valid for any pulse, here used around the ack bit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_oe <= 1'b0;
    end else begin
      scl_oe <= rx_set || rd_set || (wr_valid && !wr_ready) || (rd_req && !rd_valid) ||
                wr_hs || rd_hs || (setup_cnt_q > `ITAS_SETUP_W'(1));
    end
  end

  // pads only ever pull low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  // addressed transfer in progress, ends with stop or a missed restart
  always_ff @(posedge clk) begin
    if (!resetn || ev_stop) begin
      busy <= 1'b0;
    end else if (state_q == itas_pkg::ST_ADDR && ev_fall && byte_done) begin
      busy <= addr_match;
    end
  end

  // edge detection at the core clock covers 100 and 400 kHz alike

  AST_NO_ANSWER_UNLOCKED: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == itas_pkg::ST_ADDR && !resp_en) |=> !sda_oe || $past(sda_oe))
    else $error("answered before address set and port enabled");

  AST_STRETCH_RX: assert property (@(posedge clk) disable iff (!resetn)
    (wr_valid && !wr_ready) |=> scl_oe)
    else $error("scl not held while received byte waits");

  AST_STRETCH_TX: assert property (@(posedge clk) disable iff (!resetn)
    (rd_req && !rd_valid) |=> scl_oe)
    else $error("scl not held while transmit byte waits");

  AST_SETUP_BEFORE_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
    (rd_hs || wr_hs) |=> scl_oe [*8])
    else $error("scl released without data setup time");

  AST_RELEASE_BOUND: assert property (@(posedge clk) disable iff (!resetn)
    (rd_hs && !ev_start && !ev_stop) |-> ##[1:60] !scl_oe)
    else $error("scl not released after core answered");

  AST_ACK_RX: assert property (@(posedge clk) disable iff (!resetn)
    (rx_set && !ev_start && !ev_stop) |=> sda_oe && wr_valid && wr_data == $past(shift_q))
    else $error("received byte not acknowledged");

  AST_ACK_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == itas_pkg::ST_ADDR_ACK) |-> busy)
    else $error("address ack without transfer flag");

  AST_SUBADDR: assert property (@(posedge clk) disable iff (!resetn)
    (wr_hs && wr_index == `ITAS_IDX_SUBADDR) |=> sub_addr == $past(wr_data))
    else $error("sub-address not taken from first written byte");

  AST_COUNT: assert property (@(posedge clk) disable iff (!resetn)
    (wr_hs && wr_index == `ITAS_IDX_COUNT) |=> byte_count == $past(wr_data))
    else $error("byte count not taken from second written byte");

endmodule : itas_target

// ==== itas_ctl_model.sv ====
/*
  Bus controller model for the i2c target port: start, stop, byte write
  and byte read with stretch tolerance. Assumes pull-ups on scl and sda.
*/
`timescale 1ns/1ps

module itas_ctl_model (
  // core clock for timing
  input  wire logic clk,
  // resolved bus levels
  input  wire logic scl,
  input  wire logic sda,
  // pull-downs, high while driving low
  output logic      scl_oe,
  output logic      sda_oe
);
  int hp = 20;   // half bit in clk cycles; the bench slows it for rate tests
  int stretch;   // longest wait for scl seen since last clear

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stretch = 0;
  end

  // one clock pulse; the high half is timed from when scl is really seen high or after 4000 cycles of waiting
  task automatic clk_pulse(output logic s);
    int n;
    n = 0;
    repeat (hp) @(negedge clk);
    scl_oe = 1'b0;
    while (!scl && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n > stretch)
      stretch = n;
    repeat (hp) @(negedge clk);
    s = sda;
    scl_oe = 1'b1;
    repeat (2) @(negedge clk); // hold so sda never moves with the scl fall
  endtask : clk_pulse

  // start or repeated start
  task automatic start();
    sda_oe = 1'b0;
    repeat (hp) @(negedge clk);
    scl_oe = 1'b0;
    wait (scl);
    repeat (hp) @(negedge clk);
    sda_oe = 1'b1;
    repeat (hp) @(negedge clk);
    scl_oe = 1'b1;
  endtask : start

  task automatic stop();
    sda_oe = 1'b1;
    repeat (hp) @(negedge clk);
    scl_oe = 1'b0;
    wait (scl);
    repeat (hp) @(negedge clk);
    sda_oe = 1'b0;
    repeat (hp) @(negedge clk);
  endtask : stop

  // msb first, then the target's acknowledge
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_oe = !b[i];
      clk_pulse(s);
    end
    sda_oe = 1'b0;
    clk_pulse(s);
    ack = !s;
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] b);
    logic s;
    sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(s);
      b[i] = s;
    end
    sda_oe = !nack;
    clk_pulse(s); // next byte or stop sets sda, so it is written once per step
  endtask : rd_byte
endmodule : itas_ctl_model

// ==== i2c_target_address_and_stretch_test.sv ====
/*
  Self-checking bench for itas_target: straps, address gating, writes,
  reads and a slow rate. Assumes itas_ctl_model as the bus controller.
*/
`timescale 1ns/1ps

module i2c_target_address_and_stretch_test;
  localparam logic [6:0] ADDR = 7'h2d; // port 2, pins b=0 a=1, code 5
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        port2_sel = 1'b0;
  logic        addr_strap_pin_a = 1'b0;
  logic        addr_strap_pin_b = 1'b0;
  logic [2:0]  strap_code = 3'h0;
  logic        decode_done = 1'b0;
  logic        port_enable = 1'b0;
  logic        wr_ready = 1'b0;
  logic        rd_valid = 1'b0;
  logic [7:0]  rd_data = 8'h00;
  logic        t_scl_oe, t_sda_oe, c_scl_oe, c_sda_oe, t_scl_o, t_sda_o;
  logic [6:0]  own_addr;
  logic        addr_locked, primary, wr_valid, rd_req, busy;
  logic [7:0]  wr_data, wr_index, sub_addr, byte_count, rd_index;
  int          error_cnt = 0, checked = 0, cyc = 0, lat = 0, wait_n = 0;
  logic [15:0] wlog[$];
  wire         scl = !c_scl_oe && !(t_scl_oe && !t_scl_o); // pull-up when nobody pulls low
  wire         sda = !c_sda_oe && !(t_sda_oe && !t_sda_o);

  always #2.5 clk = ~clk;

  itas_target DUT (.clk(clk), .resetn(resetn), .port2_sel(port2_sel),
    .addr_strap_pin_a(addr_strap_pin_a), .addr_strap_pin_b(addr_strap_pin_b),
    .strap_code(strap_code), .decode_done(decode_done), .port_enable(port_enable),
    .scl_i(scl), .scl_o(t_scl_o), .scl_oe(t_scl_oe), .sda_i(sda), .sda_o(t_sda_o),
    .sda_oe(t_sda_oe),
    .own_addr(own_addr), .addr_locked(addr_locked), .primary(primary),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_index(wr_index), .wr_ready(wr_ready),
    .sub_addr(sub_addr), .byte_count(byte_count), .rd_req(rd_req), .rd_index(rd_index),
    .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy));

  itas_ctl_model ctl (.clk(clk), .scl(scl), .sda(sda), .scl_oe(c_scl_oe), .sda_oe(c_sda_oe));

  // core side answers after lat cycles, so a slow core forces a stretch
  always @(negedge clk) begin
    wait_n = (wr_valid || rd_req) ? wait_n + 1 : 0;
    wr_ready = wr_valid && wait_n > lat;
    rd_valid = rd_req && wait_n > lat;
    rd_data = 8'ha5 ^ rd_index;
  end

  // log of accepted bytes as {index, data}
  always @(posedge clk) begin
    if (wr_valid && wr_ready)
      wlog.push_back({wr_index, wr_data});
  end

  // hang guard, well above the roughly 55000 cycles the whole run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic reset_to(input logic p2, input logic a, input logic b, input logic [2:0] c);
    resetn = 1'b0;
    port2_sel = p2;
    addr_strap_pin_a = a;
    addr_strap_pin_b = b;
    strap_code = c;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask : reset_to

  task automatic latch();
    decode_done = 1'b1;
    @(negedge clk);
    decode_done = 1'b0;
    repeat (2) @(negedge clk);
  endtask : latch

  task automatic probe(input logic [6:0] a, output logic ack);
    ctl.start();
    ctl.wr_byte({a, 1'b0}, ack);
    ctl.stop();
  endtask : probe

  // port 1 forces bits 4 and 5 with either pin high and the other low, every strap code
  task automatic t_straps();
    for (int c = 0; c < 8; c++) begin
      reset_to(1'b0, c[0], !c[0], 3'(c));
      latch();
      chk("port1 addr", own_addr, {4'h7, 3'(c)});
      chk("primary", primary, c == 0);
      chk("locked", addr_locked, 1'b1);
    end
    $display("test straps done");
  endtask : t_straps

  task automatic t_gate();
    logic ack;
    reset_to(1'b1, 1'b1, 1'b0, 3'h5);
    port_enable = 1'b1;
    probe(7'h00, ack); // own_addr still reads 0, so only the lock can refuse
    chk("unlocked ack", ack, 1'b0);
    latch();
    chk("port2 addr", own_addr, ADDR);
    addr_strap_pin_b = 1'b1;
    strap_code = 3'h2;
    latch();
    chk("held addr", own_addr, ADDR);
    port_enable = 1'b0;
    probe(ADDR, ack);
    chk("disabled ack", ack, 1'b0);
    port_enable = 1'b1;
    $display("test gate done");
  endtask : t_gate

  task automatic t_write(input int l);
    logic [7:0] msg[4] = '{8'h3c, 8'h02, 8'h81, 8'h7e};
    logic       ack;
    lat = l;
    wlog.delete();
    ctl.stretch = 0;
    probe(ADDR, ack);
    wlog.delete();
    ctl.start();
    ctl.wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
    chk("foreign ack", ack, 1'b0);
    ctl.stop();
    ctl.start();
    ctl.wr_byte({ADDR, 1'b0}, ack);
    chk("addr ack", ack, 1'b1);
    chk("busy on", busy, 1'b1);
    foreach (msg[i]) begin
      ctl.wr_byte(msg[i], ack);
      chk("data ack", ack, 1'b1);
    end
    ctl.stop();
    repeat (4) @(negedge clk);
    chk("busy", busy, 1'b0);
    chk("sub_addr", sub_addr, 8'h3c);
    chk("byte_count", byte_count, 8'h02);
    foreach (msg[i]) chk("logged byte", wlog[i], {8'(i), msg[i]});
    chk("stretch", ctl.stretch > l, 1'b1);
    $display("test write done");
  endtask : t_write

  // sub-address write, repeated start, count byte, data, nack
  task automatic t_read();
    logic       ack;
    logic [7:0] b;
    lat = 30;
    ctl.stretch = 0;
    ctl.start();
    ctl.wr_byte({ADDR, 1'b0}, ack);
    ctl.wr_byte(8'h05, ack);
    chk("sub ack", ack, 1'b1);
    ctl.start();
    ctl.wr_byte({ADDR, 1'b1}, ack);
    chk("read addr ack", ack, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ctl.rd_byte(i == 2, b);
      chk("read byte", b, 8'ha5 ^ 8'(i));
    end
    ctl.stop();
    chk("read sub_addr", sub_addr, 8'h05);
    chk("read stretch", ctl.stretch > lat, 1'b1);
    $display("test read done");
  endtask : t_read

  task automatic t_rate();
    logic ack;
    ctl.hp = 1000; // 5 us halves: 100 kbps, high time past 4 us after a rise
    lat = 0;
    ctl.start();
    ctl.wr_byte({ADDR, 1'b0}, ack);
    chk("slow addr ack", ack, 1'b1);
    ctl.wr_byte(8'h11, ack);
    ctl.stop();
    chk("slow sub_addr", sub_addr, 8'h11);
    ctl.hp = 20;
    $display("test rate done");
  endtask : t_rate

  initial begin
    t_straps();
    t_gate();
    t_write(100);
    t_write(0);
    t_read();
    t_rate();
    results();
  end
endmodule : i2c_target_address_and_stretch_test
